/* File: rtl/clk_stop_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts for the stop control
// Assumes: one 8-bit register port inside the device, 125 MHz system clock
// Notes:   rule digest follows
// Operation
// - bits 6 and 5 let request pin B stop reference pairs 4 and 2
// - bits 3,2,1,0 let request pin A stop reference pairs 7,5,3,1
// - request pin level valid after two equal reference rising edges
// - pin low: stopped reference pairs restart together glitch free in 2-6 periods
// - pin high: assigned reference pairs halt after their next transition
// - halted reference pair ends low with both outputs undriven
// - shared pin is supply-good low-active first, then power-down high-active
// - power-down request synchronised; clocks parked before oscillators switch off
// - power-down seen on two processor edges; outputs park within four periods
// - drive-mode 0 parks true high and complement floating; 1 floats both
// - stable clocks within 1.8 ms after power-down release
// - leaving power-down waits for lock, then enables all outputs together; the logic enables each group on its own phase edge
// - processor halt low stops stoppable pairs 2-6 periods after two-edge sampling
// - halted processor pair: true driven high, complement low floating, same drive
// - processor halt high restarts stopped pairs within two periods, no runt pulses
// - PCI halt low stops PCI outputs synchronously; free-running ones keep toggling
// - PCI halt high restarts all stoppable PCI outputs within two periods
// - reference outputs per pin follow the assignment register
`ifndef CLK_STOP_REGS_SVH
`define CLK_STOP_REGS_SVH
`define REF_ASSIGN_ADDR   8'h0A
`define REF_ASSIGN_RESET  8'h00
`define REF_ASSIGN_MASK   8'h6F
`define ASSIGN_A_PAIR1    0
`define ASSIGN_A_PAIR3    1
`define ASSIGN_A_PAIR5    2
`define ASSIGN_A_PAIR7    3
`define ASSIGN_B_PAIR2    5
`define ASSIGN_B_PAIR4    6
`define CLOCK_PERIOD_NS   8
`define POWERUP_MAX_NS    1800000
`define POWERUP_CYCLES    (`POWERUP_MAX_NS / `CLOCK_PERIOD_NS)
`define CPU_STOP_PERIODS  2
`endif

/* File: rtl/clk_stop_pkg.sv */
// Purpose: shared types of the stop control
// Assumes: nothing
// Notes:   pin groups travel as packed structs
package clk_stop_pkg;
  typedef struct packed {
    logic t;     // true output level
    logic t_oe;  // true output driven
    logic c;     // complement output level
    logic c_oe;  // complement output driven
  } diff_pin_t;

  typedef struct packed {
    logic o;     // output level
    logic oe;    // output driven
  } se_pin_t;

  // gray along boot, wake, run, park, off
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_WAKE = 3'h4,
    ST_RUN  = 3'h5,
    ST_PARK = 3'h7,
    ST_OFF  = 3'h6
  } pwr_state_t;
endpackage

/* File: rtl/stop_pin_filter.sv */
// Purpose: two-flop synchroniser plus two-sample debounce for one request pin
// Assumes: sample is in the clock domain, a one-cycle pulse or held high
// Notes:   level changes only after two equal samples in a row
`timescale 1ns/1ps
module stop_pin_filter #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clock,    // system clock
  input  wire logic reset_n,  // async reset, active low
  input  wire logic pin,      // asynchronous pin
  input  wire logic sample,   // sampling strobe
  output logic      level     // debounced level
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // first flop feeds only the second
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= INIT;
      sync_r <= INIT;
    end
    else
    begin
      meta_r <= pin;
      sync_r <= meta_r;
    end
  end

  // accept a level seen on two successive strobes
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_r <= INIT;
      level  <= INIT;
    end
    else if (sample)
    begin
      prev_r <= sync_r;
      if (prev_r == sync_r)
        level <= sync_r;
    end
  end
endmodule // stop_pin_filter

/* File: rtl/clock_output_stop_control.sv */
// Purpose: gates and parks generator outputs on stop and power-down requests
// Assumes: phase inputs are the synthesiser's output phases on this clock
// Notes:   analog drive strength is outside this block; oe marks driven pins
`timescale 1ns/1ps
`include "clk_stop_regs.svh"
module clock_output_stop_control
  import clk_stop_pkg::*;
#(
  parameter int N_CPU          = 2,
  parameter int N_PCI          = 6,
  parameter int POWERUP_CYCLES = `POWERUP_CYCLES
) (
  input  wire logic             clock,                // 125 MHz system clock
  input  wire logic             reset_n,              // async reset, active low
  input  wire logic             ref_stop_request_a,   // stop request A, async
  input  wire logic             ref_stop_request_b,   // stop request B, async
  input  wire logic             processor_clock_halt, // processor halt, low active
  input  wire logic             pci_clock_halt,       // PCI halt, low active
  input  wire logic             supply_good_strobe,   // supply-good / power-down pin
  input  wire logic             ref_phase,            // reference true phase
  input  wire logic             cpu_phase,            // processor true phase
  input  wire logic             pci_phase,            // PCI phase
  input  wire logic [N_CPU-1:0] cpu_stoppable,        // pair obeys processor halt
  input  wire logic [N_PCI-1:0] pci_free_run,         // output ignores PCI halt
  input  wire logic [7:0]       ref_drive_mode,       // power-down drive mode per pair
  input  wire logic [N_CPU-1:0] cpu_drive_mode,       // power-down drive mode per pair
  input  wire logic             pll_locked,           // synthesiser lock
  input  wire logic [7:0]       reg_addr,             // register index
  input  wire logic [7:0]       reg_wdata,            // write data
  input  wire logic             reg_write,            // write strobe
  output logic      [7:0]       reg_rdata,            // read data, registered
  output diff_pin_t [7:0]       reference_clock_pair, // reference pairs
  output diff_pin_t [N_CPU-1:0] processor_clock_pair, // processor pairs
  output se_pin_t   [N_PCI-1:0] pci_clock,            // PCI outputs
  output logic                  osc_enable,           // crystal oscillator on
  output logic                  pll_power,            // synthesiser powered
  output logic                  lock_late,            // lock overran power-up time
  output pwr_state_t            power_state           // power state
);
  localparam int TW = $clog2(POWERUP_CYCLES + 1);

  pwr_state_t       state_r;
  pwr_state_t       state_nxt;
  logic [7:0]       assign_r;
  logic             ref_ph_d;
  logic             cpu_ph_d;
  logic             pci_ph_d;
  logic             ref_rise;
  logic             ref_fall;
  logic             cpu_rise;
  logic             pci_fall;
  logic             req_a;
  logic             req_b;
  logic             cpu_halt_lvl;
  logic             pci_halt_lvl;
  logic             pd_lvl;
  logic             pd_sample;
  logic [7:0]       ref_stop;
  logic [7:0]       ref_en_r;
  logic [N_CPU-1:0] cpu_en_r;
  logic             cpu_halt_r;
  logic [2:0]       cpu_dly_r;
  logic [N_PCI-1:0] pci_en_r;
  logic             ref_park_r;
  logic             cpu_park_r;
  logic             pci_park_r;
  logic             run_ok;
  logic [TW-1:0]    lock_cnt_r;

  // phase edge detectors; phases come from same-clock logic
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_ph_d <= 1'b0;
      cpu_ph_d <= 1'b0;
      pci_ph_d <= 1'b0;
    end
    else
    begin
      ref_ph_d <= ref_phase;
      cpu_ph_d <= cpu_phase;
      pci_ph_d <= pci_phase;
    end
  end

  assign ref_rise = ref_phase & ~ref_ph_d;
  assign ref_fall = ~ref_phase & ref_ph_d;
  assign cpu_rise = cpu_phase & ~cpu_ph_d;
  assign pci_fall = ~pci_phase & pci_ph_d;
  assign run_ok   = (state_r == ST_RUN);

  // pins may move at any time, so each one is synchronised here
  stop_pin_filter #(.INIT(1'b0)) u_req_a (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     (ref_stop_request_a),
    .sample  (ref_rise),
    .level   (req_a)
  );

  stop_pin_filter #(.INIT(1'b0)) u_req_b (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     (ref_stop_request_b),
    .sample  (ref_rise),
    .level   (req_b)
  );

  stop_pin_filter #(.INIT(1'b1)) u_cpu_halt (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     (processor_clock_halt),
    .sample  (cpu_rise),
    .level   (cpu_halt_lvl)
  );

  stop_pin_filter #(.INIT(1'b1)) u_pci_halt (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     (pci_clock_halt),
    .sample  (1'b1),
    .level   (pci_halt_lvl)
  );

  // processor phase stops once oscillators are off, so sample every cycle then
  assign pd_sample = (state_r == ST_RUN) ? cpu_rise : 1'b1;

  stop_pin_filter #(.INIT(1'b1)) u_pd (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     (supply_good_strobe),
    .sample  (pd_sample),
    .level   (pd_lvl)
  );

  // assignment register; reserved bits never store
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      assign_r <= `REF_ASSIGN_RESET;
    else if (reg_write && reg_addr == `REF_ASSIGN_ADDR)
      assign_r <= reg_wdata & `REF_ASSIGN_MASK;
  end

  // registered read; unmapped indices read zero
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_addr == `REF_ASSIGN_ADDR)
      reg_rdata <= assign_r;
    else
      reg_rdata <= 8'h00;
  end

  // which reference pairs each request pin may stop
  always_comb
  begin
    ref_stop    = 8'h00;
    ref_stop[1] = req_a & assign_r[`ASSIGN_A_PAIR1];
    ref_stop[3] = req_a & assign_r[`ASSIGN_A_PAIR3];
    ref_stop[5] = req_a & assign_r[`ASSIGN_A_PAIR5];
    ref_stop[7] = req_a & assign_r[`ASSIGN_A_PAIR7];
    ref_stop[2] = req_b & assign_r[`ASSIGN_B_PAIR2];
    ref_stop[4] = req_b & assign_r[`ASSIGN_B_PAIR4];
  end

  // power sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_BOOT: if (!pd_lvl) state_nxt = ST_WAKE;
      ST_WAKE: if (pd_lvl) state_nxt = ST_PARK;
               else if (pll_locked) state_nxt = ST_RUN;
      ST_RUN:  if (pd_lvl) state_nxt = ST_PARK;
      ST_PARK: if (ref_park_r && cpu_park_r && pci_park_r)
                 state_nxt = ST_OFF;
      ST_OFF:  if (!pd_lvl) state_nxt = ST_WAKE;
      default: state_nxt = ST_BOOT;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= ST_BOOT;
    else
      state_r <= state_nxt;
  end

  // oscillators stay on until every group is parked
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_enable <= 1'b1;
      pll_power  <= 1'b1;
    end
    else
    begin
      osc_enable <= (state_nxt != ST_OFF);
      pll_power  <= (state_nxt != ST_OFF);
    end
  end

  // watchdog on the lock wait; flags a missed power-up budget
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_cnt_r <= '0;
      lock_late  <= 1'b0;
    end
    else if (state_r != ST_WAKE)
      lock_cnt_r <= '0;
    else if (lock_cnt_r == TW'(POWERUP_CYCLES))
      lock_late <= 1'b1;
    else
      lock_cnt_r <= lock_cnt_r + 1'b1;
  end

  // park flags: each group parks on its own edge while power-down is pending
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_park_r <= 1'b0;
      cpu_park_r <= 1'b0;
      pci_park_r <= 1'b0;
    end
    else if (state_r != ST_PARK && state_r != ST_OFF)
    begin
      ref_park_r <= 1'b0;
      cpu_park_r <= 1'b0;
      pci_park_r <= 1'b0;
    end
    else if (state_r == ST_PARK)
    begin
      if (ref_rise) ref_park_r <= 1'b1;
      if (cpu_rise) cpu_park_r <= 1'b1;
      if (pci_fall) pci_park_r <= 1'b1;
    end
  end

  // enables change only while the phase is low and hold through park, so no runt pulse
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ref_en_r <= 8'h00;
    else if (state_r != ST_RUN && state_r != ST_PARK)
      ref_en_r <= 8'h00;
    else if (ref_fall)
      ref_en_r <= ~ref_stop;
  end

  // processor halt: count periods after the filtered pin, act on a rise
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpu_dly_r  <= 3'h0;
      cpu_halt_r <= 1'b0;
    end
    else if (cpu_halt_lvl || (state_r != ST_RUN && state_r != ST_PARK))
    begin
      cpu_dly_r <= 3'h0;
      if (cpu_rise || (state_r != ST_RUN && state_r != ST_PARK))
        cpu_halt_r <= 1'b0;
    end
    else if (cpu_rise)
    begin
      if (cpu_dly_r == 3'(`CPU_STOP_PERIODS))
        cpu_halt_r <= 1'b1;
      else
        cpu_dly_r <= cpu_dly_r + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      cpu_en_r <= '0;
    else if (state_r != ST_RUN && state_r != ST_PARK)
      cpu_en_r <= '0;
    else if (cpu_rise)
      cpu_en_r <= '1;
  end

  // PCI enables move on the falling phase; free-running outputs ignore halt
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pci_en_r <= '0;
    else if (state_r != ST_RUN && state_r != ST_PARK)
      pci_en_r <= '0;
    else if (pci_fall)
      pci_en_r <= pci_free_run | {N_PCI{pci_halt_lvl}};
  end

  // reference pins: parked per drive mode, stopped pairs undriven low
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      reference_clock_pair <= '0;
    else
      for (int i = 0; i < 8; i++)
      begin
        if (ref_park_r)
        begin
          reference_clock_pair[i].t    <= ~ref_drive_mode[i];
          reference_clock_pair[i].t_oe <= ~ref_drive_mode[i];
          reference_clock_pair[i].c    <= 1'b0;
          reference_clock_pair[i].c_oe <= 1'b0;
        end
        else if (ref_en_r[i])
        begin
          reference_clock_pair[i].t    <= ref_ph_d;
          reference_clock_pair[i].t_oe <= 1'b1;
          reference_clock_pair[i].c    <= ~ref_ph_d;
          reference_clock_pair[i].c_oe <= 1'b1;
        end
        else
          reference_clock_pair[i] <= '0;
      end
  end

  // processor pins: halted pairs rest true high, complement low floating
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      processor_clock_pair <= '0;
    else
      for (int i = 0; i < N_CPU; i++)
      begin
        if (cpu_park_r)
        begin
          processor_clock_pair[i].t    <= ~cpu_drive_mode[i];
          processor_clock_pair[i].t_oe <= ~cpu_drive_mode[i];
          processor_clock_pair[i].c    <= 1'b0;
          processor_clock_pair[i].c_oe <= 1'b0;
        end
        else if (cpu_halt_r && cpu_stoppable[i] && cpu_en_r[i])
        begin
          processor_clock_pair[i].t    <= 1'b1;
          processor_clock_pair[i].t_oe <= 1'b1;
          processor_clock_pair[i].c    <= 1'b0;
          processor_clock_pair[i].c_oe <= 1'b0;
        end
        else if (cpu_en_r[i])
        begin
          processor_clock_pair[i].t    <= cpu_ph_d;
          processor_clock_pair[i].t_oe <= 1'b1;
          processor_clock_pair[i].c    <= ~cpu_ph_d;
          processor_clock_pair[i].c_oe <= 1'b1;
        end
        else
          processor_clock_pair[i] <= '0;
      end
  end

  // PCI pins: single-ended, held low and driven when stopped or parked
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pci_clock <= '0;
    else
      for (int i = 0; i < N_PCI; i++)
      begin
        pci_clock[i].o  <= pci_en_r[i] & pci_ph_d & ~pci_park_r;
        pci_clock[i].oe <= run_ok | (state_r == ST_PARK) | pci_park_r;
      end
  end

  assign power_state = state_r;
endmodule // clock_output_stop_control

/* File: verif/clock_output_stop_control_properties.sv */
// Purpose: concurrent checks on the stop control ports
// Assumes: ref and cpu phases of four cycles, pci of eight
// Notes:   the assignment register is mirrored from the write strobe
`timescale 1ns/1ps
module clock_output_stop_control_properties
  import clk_stop_pkg::*;
#(
  parameter int N_CPU = 2,
  parameter int N_PCI = 6
) (
  input wire logic             clock,                // system clock
  input wire logic             reset_n,              // async reset
  input wire logic             ref_stop_request_a,   // request A
  input wire logic             processor_clock_halt, // cpu halt
  input wire logic             pci_clock_halt,       // pci halt
  input wire logic [N_CPU-1:0] cpu_stoppable,        // cpu stoppable
  input wire logic [N_PCI-1:0] pci_free_run,         // pci free run
  input wire logic [7:0]       ref_drive_mode,       // park mode
  input wire logic [7:0]       reg_addr,             // register index
  input wire logic [7:0]       reg_wdata,            // write data
  input wire logic             reg_write,            // write strobe
  input wire logic [7:0]       reg_rdata,            // read data
  input diff_pin_t [7:0]       reference_clock_pair, // reference pairs
  input diff_pin_t [N_CPU-1:0] processor_clock_pair, // cpu pairs
  input se_pin_t   [N_PCI-1:0] pci_clock,            // pci outputs
  input wire logic             osc_enable,           // oscillator on
  input pwr_state_t            power_state           // power state
);
  logic [7:0] asg_r;
  logic [5:0] req_r;
  logic [5:0] cpu_r;
  logic [5:0] pci_r;
  logic       run;
  assign run = power_state == ST_RUN;
  // mirror of the assignment register
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      asg_r <= 8'h00;
    else if (reg_write && reg_addr == 8'h0A)
      asg_r <= reg_wdata & 8'h6F;
  // saturating hold-time counters, only in run so wake-up never confuses them
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      req_r <= 6'h00;
      cpu_r <= 6'h00;
      pci_r <= 6'h00;
    end
    else
    begin
      req_r <= (run && ref_stop_request_a) ? req_r + 6'(req_r != 6'h3F) : 6'h00;
      cpu_r <= (run && !processor_clock_halt) ? cpu_r + 6'(cpu_r != 6'h3F) : 6'h00;
      pci_r <= (run && !pci_clock_halt) ? pci_r + 6'(pci_r != 6'h3F) : 6'h00;
    end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_rsv; reg_rdata[7] == 1'b0 && reg_rdata[4] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read one");
  property p_wr;
    (reg_write && reg_addr == 8'h0A) ##1 (!reg_write && reg_addr == 8'h0A)
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h6F);
  endproperty
  a_wr: assert property (p_wr) else $error("readback differs");
  property p_low; run && !reference_clock_pair[1].t_oe |-> reference_clock_pair[1] == 4'h0;
  endproperty
  a_low: assert property (p_low) else $error("halted pair driven");
  property p_stop; req_r >= 6'h18 && asg_r[0] |-> reference_clock_pair[1] == 4'h0; endproperty
  a_stop: assert property (p_stop) else $error("assigned pair runs");
  property p_free; req_r >= 6'h18 && !asg_r[1] |-> reference_clock_pair[3].t_oe; endproperty
  a_free: assert property (p_free) else $error("unassigned pair stopped");
  property p_rst;
    req_r >= 6'h18 && asg_r[0] && !ref_stop_request_a |-> ##[2:24] reference_clock_pair[1].t_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("pair restart late");
  property p_halt; cpu_r >= 6'h20 && cpu_stoppable[0] |-> processor_clock_pair[0] == 4'hC;
  endproperty
  a_halt: assert property (p_halt) else $error("cpu pair not halted");
  property p_cres;
    cpu_r >= 6'h20 && cpu_stoppable[0] && processor_clock_halt
      |-> ##[1:24] processor_clock_pair[0].c_oe;
  endproperty
  a_cres: assert property (p_cres) else $error("cpu restart late");
  property p_pci; pci_r >= 6'h18 && !pci_free_run[1] |-> !pci_clock[1].o; endproperty
  a_pci: assert property (p_pci) else $error("pci output runs");
  property p_osc;
    $fell(osc_enable) |-> power_state == ST_OFF && $past(power_state) == ST_PARK;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator off early");
  property p_park;
    power_state == ST_OFF |-> reference_clock_pair[2] == (ref_drive_mode[2] ? 4'h0 : 4'hC);
  endproperty
  a_park: assert property (p_park) else $error("park level wrong");
  c_off: cover property (power_state == ST_OFF);
  c_req: cover property (req_r >= 6'h18 && asg_r[0]);
  c_cpu: cover property (cpu_r >= 6'h20);
endmodule // clock_output_stop_control_properties

bind clock_output_stop_control clock_output_stop_control_properties #(
  .N_CPU(N_CPU), .N_PCI(N_PCI)) u_props (.clock(clock), .reset_n(reset_n),
  .ref_stop_request_a(ref_stop_request_a), .processor_clock_halt(processor_clock_halt),
  .pci_clock_halt(pci_clock_halt), .cpu_stoppable(cpu_stoppable),
  .pci_free_run(pci_free_run), .ref_drive_mode(ref_drive_mode), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
  .reference_clock_pair(reference_clock_pair), .processor_clock_pair(processor_clock_pair),
  .pci_clock(pci_clock), .osc_enable(osc_enable), .power_state(power_state));

/* File: verif/stop_request_driver.sv */
// Purpose: platform power logic driving the stop and power-down pins
// Assumes: the bench sets wanted levels on its falling edge
// Notes:   a delay off the clock grid makes every change asynchronous
`timescale 1ns/1ps
module stop_request_driver #(
  parameter int DELAY_NS = 3
) (
  input  wire logic want_a,   // wanted request A
  input  wire logic want_b,   // wanted request B
  input  wire logic want_cpu, // wanted cpu halt
  input  wire logic want_pci, // wanted pci halt
  input  wire logic want_pd,  // wanted shared pin
  output logic      req_a,    // request A pin
  output logic      req_b,    // request B pin
  output logic      cpu_halt, // cpu halt pin
  output logic      pci_halt, // pci halt pin
  output logic      pd_pin    // supply-good then power-down
);
  // changes land between clock edges, so the device must synchronise
  assign #DELAY_NS req_a = want_a;
  assign #DELAY_NS req_b = want_b;
  assign #DELAY_NS cpu_halt = want_cpu;
  assign #DELAY_NS pci_halt = want_pci;
  // power-down shares the supply-good pin and takes the same DELAY_NS offset as the other pins
  assign #DELAY_NS pd_pin = want_pd;
endmodule // stop_request_driver

/* File: verif/test_clock_output_stop_control.sv */
// Purpose: directed test of the clock output stop control
// Assumes: phases from a cycle counter, power-up limit cut to 50
// Notes:   pins reach the design through the request driver model
`timescale 1ns/1ps
`define CHECK(what, exp, act) begin tests_run++; if ((act) !== (exp)) begin errors++; \
  $display("mismatch %s expected %h seen %h", what, exp, act); end end
`define WAIT_UNTIL(c, lim) for (int i = 0; i < lim && !(c); i++) cyc(1);
module test_clock_output_stop_control;
  import clk_stop_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, pll_locked = 1'b1, reg_write = 1'b0;
  logic want_a = 1'b0, want_b = 1'b0, want_cpu = 1'b1, want_pci = 1'b1, want_pd = 1'b1;
  logic req_a, req_b, cpu_halt, pci_halt, pd_pin, osc_enable, pll_power, lock_late;
  logic [2:0] ph_r = 3'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ref_drive_mode = 8'h00;
  logic [1:0] cpu_drive_mode = 2'b00;
  diff_pin_t [7:0] reference_clock_pair;
  diff_pin_t [1:0] processor_clock_pair;
  se_pin_t   [5:0] pci_clock;
  pwr_state_t      power_state;
  int errors = 0, tests_run = 0, cycles = 0;
  initial forever #4 clock = ~clock;
  always @(negedge clock) ph_r <= ph_r + 3'h1;
  stop_request_driver u_stop_request_driver (.want_a(want_a), .want_b(want_b),
    .want_cpu(want_cpu), .want_pci(want_pci), .want_pd(want_pd), .req_a(req_a),
    .req_b(req_b), .cpu_halt(cpu_halt), .pci_halt(pci_halt), .pd_pin(pd_pin));
  clock_output_stop_control #(.POWERUP_CYCLES(50)) u_clock_output_stop_control (
    .clock(clock), .reset_n(reset_n), .ref_stop_request_a(req_a),
    .ref_stop_request_b(req_b), .processor_clock_halt(cpu_halt), .pci_clock_halt(pci_halt),
    .supply_good_strobe(pd_pin), .ref_phase(ph_r[1]), .cpu_phase(ph_r[1]),
    .pci_phase(ph_r[2]), .cpu_stoppable(2'b01), .pci_free_run(6'h01),
    .ref_drive_mode(ref_drive_mode), .cpu_drive_mode(cpu_drive_mode),
    .pll_locked(pll_locked), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_rdata(reg_rdata), .reference_clock_pair(reference_clock_pair),
    .processor_clock_pair(processor_clock_pair), .pci_clock(pci_clock),
    .osc_enable(osc_enable), .pll_power(pll_power), .lock_late(lock_late),
    .power_state(power_state));
  task automatic cyc(input int n); repeat (n) @(negedge clock); endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    cyc(1);
    reg_write = 1'b0;
    cyc(1);
  endtask
  // read data stands once the address has been held for one edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    cyc(2);
    d = reg_rdata;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      test_done;
    end
  end
  initial
  begin
    logic [7:0] d;
    cyc(20);
    reset_n = 1'b1;
    cyc(2);
    rd(8'h0A, d); `CHECK("assign reset", 8'h00, d)
    wr(8'h0A, 8'hFF); rd(8'h0A, d); `CHECK("assign mask", 8'h6F, d)
    wr(8'h0A, 8'h21); wr(8'h0B, 8'hFF); rd(8'h0A, d); `CHECK("assign", 8'h21, d)
    rd(8'h0B, d); `CHECK("unmapped", 8'h00, d)
    want_pd = 1'b0; `WAIT_UNTIL(power_state === ST_RUN, 60)
    `CHECK("boot to run", ST_RUN, power_state)
    cyc(8); `CHECK("pair driven", 1'b1, reference_clock_pair[3].t_oe)
    want_a = 1'b1; cyc(30);
    `CHECK("pair1 stop", 4'h0, reference_clock_pair[1])
    `CHECK("pair3 free", 1'b1, reference_clock_pair[3].t_oe)
    `CHECK("pair2 other pin", 1'b1, reference_clock_pair[2].t_oe)
    want_b = 1'b1; cyc(30);
    `CHECK("pair2 stop", 4'h0, reference_clock_pair[2])
    `CHECK("pair4 free", 1'b1, reference_clock_pair[4].t_oe)
    want_a = 1'b0; want_b = 1'b0; cyc(25);
    `CHECK("pair1 back", 1'b1, reference_clock_pair[1].t_oe)
    `CHECK("pair2 back", 1'b1, reference_clock_pair[2].t_oe)
    want_a = 1'b1; cyc(1); want_a = 1'b0; d = 8'h00;
    repeat (20) begin cyc(1); d[0] |= !reference_clock_pair[1].t_oe; end
    `CHECK("short pulse", 1'b0, d[0])
    want_cpu = 1'b0; cyc(40);
    `CHECK("cpu0 halt", 4'hC, processor_clock_pair[0])
    `CHECK("cpu1 runs", 1'b1, processor_clock_pair[1].c_oe)
    want_cpu = 1'b1; `WAIT_UNTIL(processor_clock_pair[0].c_oe === 1'b1, 20)
    `CHECK("cpu0 back", 1'b1, processor_clock_pair[0].c_oe)
    want_pci = 1'b0; cyc(20); d = 8'h00;
    repeat (8) begin cyc(1); d |= {5'h00, !pci_clock[0].o, pci_clock[0].o, pci_clock[1].o}; end
    `CHECK("pci stop", 1'b0, d[0])
    `CHECK("free_running_pci_clock toggles", 2'b11, d[2:1])
    want_pci = 1'b1; `WAIT_UNTIL(pci_clock[1].o === 1'b1, 24)
    `CHECK("pci back", 1'b1, pci_clock[1].o)
    ref_drive_mode = 8'h55; cpu_drive_mode = 2'b10; want_pd = 1'b1;
    `WAIT_UNTIL(power_state === ST_OFF, 60) cyc(2);
    `CHECK("osc off", 1'b0, osc_enable)
    `CHECK("pll off", 1'b0, pll_power)
    for (int k = 0; k < 8; k++) `CHECK("ref park", (k % 2) ? 4'hC : 4'h0, reference_clock_pair[k])
    `CHECK("cpu0 park", 4'hC, processor_clock_pair[0])
    `CHECK("cpu1 park", 4'h0, processor_clock_pair[1])
    for (int k = 0; k < 6; k++) `CHECK("pci park", 2'b01, pci_clock[k])
    pll_locked = 1'b0; want_pd = 1'b0; `WAIT_UNTIL(power_state === ST_WAKE, 20)
    `CHECK("wake", ST_WAKE, power_state)
    cyc(60); `CHECK("lock late", 1'b1, lock_late)
    pll_locked = 1'b1; `WAIT_UNTIL(power_state === ST_RUN, 20)
    `CHECK("run again", ST_RUN, power_state)
    `CHECK("osc back", 1'b1, osc_enable)
    test_done;
  end
endmodule // test_clock_output_stop_control
